// ==== bench/testbench.sv ====
// self-checking bench for vil_irq_ctrl
// assumes vil_cpu_model and the bound checker are compiled first
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import vil_pkg::*;
    logic core_clk = 0, rst_b = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, cpuMask = 1, trapReq = 0, cpuAck, irqReq, wakeUp;
    logic ackOn = 0, slow = 0;
    logic [7:0] portAPins = 8'hFF, portBPins = 8'hFF;
    logic [13:0] periphFlag = 0, periphEnable = 0, periphClear = 0, f;
    logic [3:0] ackVector, irqVector;
    logic [15:0] irqAddr;
    vil_mode_t haltMode = VIL_RUN;
    int errCount = 0, nCompared = 0, cycles = 0, seed = 32'h7FCC, k;
    always #20 core_clk = ~core_clk;
    vil_irq_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .portAPins(portAPins),
        .portBPins(portBPins), .periphFlag(periphFlag), .periphEnable(periphEnable),
        .periphClear(periphClear), .cpuMask(cpuMask), .trapReq(trapReq), .cpuAck(cpuAck),
        .ackVector(ackVector), .haltMode(haltMode), .irqReq(irqReq),
        .irqVector(irqVector), .irqAddr(irqAddr), .wakeUp(wakeUp));
    vil_cpu_model cpu (.core_clk(core_clk), .rst_b(rst_b), .irqReq(irqReq),
        .irqVector(irqVector), .ackOn(ackOn), .slow(slow), .cpuAck(cpuAck),
        .ackVector(ackVector));
    task automatic finishTest();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errCount++;
            finishTest();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ----------------------------------------
    // apb master and waits
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic waitFor(input logic v);
        int n;
        n = 0;
        while (irqReq !== v && n < 12)
        begin
            @(posedge core_clk);
            n++;
        end
        check(irqReq, v);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse(input logic [13:0] v);
        periphFlag <= v;
        tick(1);
        periphFlag <= 0;
    endtask
    function automatic int lowest(input logic [13:0] v);
        for (int i = 13; i >= 0; i--)
            if (v[i])
                lowest = i;
    endfunction
    function automatic logic wakeExp(input int n, input int m);
        return (n == 0 && m == 3) || ((n == 9 || n == 11) && m == 2) || (n == 12 && m == 1);
    endfunction
    initial
    begin
        tick(4);
        rst_b <= 1;
        tick(1);
        apb(0, 12'h000, 0);
        check(rd, 32'h0);
        apb(0, 12'h004, 0);
        check(rd, 32'h0C);
        apb(0, 12'h010, 0);
        check(err, 1'b1);
        cpuMask <= 0;
        apb(1, 12'h000, 32'hFF);
        apb(0, 12'h000, 0);
        check(rd, 32'h0);
        cpuMask <= 1;
        apb(1, 12'h000, 32'h5A);
        apb(0, 12'h000, 0);
        check(rd, 32'h5A);
        $display("registers done");
        pulse(14'h0020);
        cpuMask <= 0;
        tick(8);
        check(irqReq, 0);
        cpuMask <= 1;
        periphEnable <= 14'h3FE1;
        tick(8);
        check(irqReq, 0);
        clkEn <= 0;
        cpuMask <= 0;
        tick(3);
        clkEn <= 1;
        waitFor(1);
        check(irqVector, 5);
        // drop the vector 5 flag so the priority scenario starts empty
        periphClear <= 14'h3FFF;
        tick(1);
        periphClear <= 0;
        waitFor(0);
        for (int i = 0; i < 24; i++)
        begin
            f = 14'($random(seed)) & 14'h3FE1;
            f[13] = f[13] | (i == 0) | (f == 0);
            trapReq <= (i == 3);
            pulse(f);
            trapReq <= 0;
            waitFor(1);
            if (i == 3)
                check(irqAddr, 16'hFFFC);
            tick(2);
            check(irqVector, lowest(f));
            check(irqAddr, 16'hFFFA - 16'(2 * lowest(f)));
            periphClear <= 14'h3FFF;
            tick(1);
            periphClear <= 0;
            waitFor(0);
        end
        $display("priority done");
        cpuMask <= 1;
        foreach (f[n])
            for (int m = 1; m < 4; m++)
                if (!(n inside {[1:4]}) && !(n == 12 && m != 1))
                begin
                    haltMode <= vil_mode_t'(m);
                    pulse(14'h1 << n);
                    tick(6);
                    check(wakeUp, wakeExp(n, m));
                    periphClear <= 14'h3FFF;
                    tick(1);
                    periphClear <= 0;
                    tick(3);
                end
        haltMode <= VIL_RUN;
        $display("wake done");
        ackOn <= 1;
        for (int s = 0; s < 4; s++)
        begin
            k = $random(seed) & 3;
            slow <= s[0];
            cpuMask <= 1;
            // line b sits on A7 with low-level sense: keep it high
            portAPins <= 8'($random(seed)) | 8'h80 | (8'h1 << k);
            apb(1, 12'h004, 32'h0C | k);
            apb(1, 12'h000, s);
            tick(6);
            cpuMask <= 0;
            portAPins[k] <= 0;
            waitFor(s != 1);
            if (s != 1)
                check(irqVector, 1);
            tick(10);
            check(irqReq, s == 0);
            portAPins[k] <= 1;
            waitFor(s[0]);
            waitFor(0);
        end
        $display("line sense done");
        cpuMask <= 1;
        portAPins <= 8'hFF;
        apb(1, 12'h004, 32'hCC);
        apb(1, 12'h000, 32'h80);
        tick(6);
        cpuMask <= 0;
        portBPins[0] <= 0;
        waitFor(1);
        check(irqVector, 4);
        waitFor(0);
        cpuMask <= 1;
        portBPins[0] <= 1;
        tick(6);
        portBPins[0] <= 0;
        tick(6);
        apb(1, 12'h000, 32'hC0);
        cpuMask <= 0;
        tick(8);
        check(irqReq, 0);
        cpuMask <= 1;
        // line d falls back to low-level sense on B0, so release it first
        portBPins[0] <= 1;
        apb(1, 12'h004, 32'h1C);
        apb(1, 12'h000, 32'h20);
        haltMode <= VIL_HALT;
        portBPins[4] <= 0;
        tick(8);
        check(wakeUp, 0);
        $display("pin select done");
        finishTest();
    end
endmodule
`default_nettype wire

// ==== bench/vil_cpu_model.sv ====
// cpu core stand-in: enters the routine of a presented vector request, never the trap (vector F)
// assumes the mask bit is driven by the testbench
`default_nettype none
module vil_cpu_model
(
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, low active
    input wire logic irqReq, // request from controller
    input wire logic [3:0] irqVector, // vector presented
    input wire logic ackOn, // accept requests
    input wire logic slow, // long gap after each entry
    output logic cpuAck, // routine entered
    output logic [3:0] ackVector // vector entered
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] waitQ;
    // gap between entries so the request pipeline drops first
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpuAck <= 1'b0;
            ackVector <= 4'h0;
            waitQ <= 3'h0;
        end
        else
        begin
            cpuAck <= 1'b0;
            ackVector <= ~ackVector;
            if (waitQ != 3'h0)
                waitQ <= waitQ - 3'h1;
            else if (ackOn && irqReq && irqVector != 4'hF)
            begin
                cpuAck <= 1'b1;
                ackVector <= irqVector;
                waitQ <= slow ? 3'h7 : 3'h4;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/vil_irq_ctrl_asserts.sv ====
// checker for vil_irq_ctrl: request, vector and bus relations
// assumes it is bound to every vil_irq_ctrl instance
`default_nettype none
module vil_irq_ctrl_asserts
#(
    parameter int NUM_VEC = 14
)
(
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, low active
    input wire logic clkEn, // run enable
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic cpuMask, // mask bit
    input wire logic trapReq, // software trap
    input wire logic irqReq, // request out
    input wire logic [3:0] irqVector, // vector out
    input wire logic [15:0] irqAddr // handler address
);
    // ----------------------------------------
    // relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence trapOut;
        irqReq && irqVector == 4'hF && irqAddr == 16'hFFFC;
    endsequence
    sequence regRead;
        psel && penable && !pwrite && paddr < 12'h008;
    endsequence
    trap_wins_a: assert property (trapReq && clkEn |=> trapOut)
        else $error("trap request not presented");
    trap_mask_a: assert property (trapReq && cpuMask && clkEn |=> irqReq)
        else $error("trap held back by mask");
    mask_blocks_a: assert property (cpuMask && !trapReq && clkEn |=> !irqReq)
        else $error("request passed while masked");
    masked_req_a: assert property (irqReq && irqVector != 4'hF && $past(clkEn) |-> !$past(cpuMask))
        else $error("vector request without clear mask");
    vec_range_a: assert property (irqReq |-> irqVector < NUM_VEC || irqVector == 4'hF)
        else $error("vector number out of range");
    vec_addr_a: assert property (irqReq && irqVector != 4'hF |-> irqAddr == 16'hFFFA - {11'h0, irqVector, 1'b0})
        else $error("handler address wrong");
    upper_zero_a: assert property (regRead |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    freeze_hold_a: assert property (!clkEn |=> $stable(irqReq) && $stable(irqAddr))
        else $error("state moved while frozen");
endmodule
bind vil_irq_ctrl vil_irq_ctrl_asserts #(.NUM_VEC(NUM_VEC)) chk (.core_clk(core_clk),
    .rst_b(rst_b), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .cpuMask(cpuMask), .trapReq(trapReq),
    .irqReq(irqReq), .irqVector(irqVector), .irqAddr(irqAddr));
`default_nettype wire

// ==== rtl/vil_consts.svh ====
// constants for the vectored interrupt / external line controller
// assumes inclusion by bare name from rtl files
`ifndef VIL_CONSTS_SVH
`define VIL_CONSTS_SVH
// apb byte offsets
`define VIL_OFF_SENSE 12'h000
`define VIL_OFF_PINSEL 12'h004
`define VIL_OFF_PEND 12'h008
`define VIL_OFF_VECT 12'h00C
// reset values
`define VIL_SENSE_RST 8'h00
`define VIL_PINSEL_RST 8'h0C
// vector table base: vector n at base - 2n, reset and trap above
`define VIL_VEC_RESET 16'hFFFE
`define VIL_VEC_TRAP 16'hFFFC
`define VIL_VEC_BASE 16'hFFFA
// field positions of per-line two-bit fields
`define VIL_FLD_D 6
`define VIL_FLD_C 4
`define VIL_FLD_B 2
`define VIL_FLD_A 0
// vector numbers
`define VIL_VN_LINE_A 1
`define VIL_VN_LINE_C 3
`define VIL_NUM_VEC 14
`endif

// ==== rtl/vil_irq_ctrl.sv ====
// vectored interrupt controller with four external lines, apb registers
// assumes cpu supplies mask bit, ack with vector number and halt mode
//
// Added by the designer: the address map and the APB register port.
`include "vil_consts.svh"
`default_nettype none
module vil_irq_ctrl
    import vil_pkg::*;
#(
    parameter int NUM_VEC = `VIL_NUM_VEC
)
(
    input wire logic core_clk, // system clock, 25 MHz
    input wire logic rst_b, // async reset, low active
    input wire logic clkEn, // freezes all state while low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address or write to a read-only register
    input wire logic [7:0] portAPins, // port A pins, asynchronous
    input wire logic [7:0] portBPins, // port B pins, asynchronous
    input wire logic [NUM_VEC-1:0] periphFlag, // peripheral flags, core_clk domain
    input wire logic [NUM_VEC-1:0] periphEnable, // peripheral enable bits
    input wire logic [NUM_VEC-1:0] periphClear, // peripheral clears its flag
    input wire logic cpuMask, // interrupt mask bit of cpu_condition_reg
    input wire logic trapReq, // software trap executed
    input wire logic cpuAck, // cpu enters routine of ackVector
    input wire logic [3:0] ackVector, // vector number being entered
    input wire vil_mode_t haltMode, // current low power mode
    output logic irqReq, // request to cpu, unmasked winner exists or trap executed
    output logic [3:0] irqVector, // winning vector number
    output logic [15:0] irqAddr, // handler address of winner
    output logic wakeUp // wake from current halt mode
);
    import vil_pkg::*;

    initial
    begin
        if (NUM_VEC != `VIL_NUM_VEC)
            $error("vil_irq_ctrl: vector table is fixed at 14 entries");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sense;
        logic [7:0] pinSel;
        logic [NUM_VEC-1:0] pend;
        logic reqOut;
        logic [3:0] vecOut;
        logic [15:0] addrOut;
        logic wakeOut;
        logic [31:0] rdata;
    } vil_state_t;
    vil_state_t st_q, st_d;

    // per-vector halt wake class, fixed by the vector map
    localparam vil_wake_t WAKE_CLASS [0:13] = '{
        VIL_WAKE_OSC,
        VIL_WAKE_HALT, VIL_WAKE_HALT, VIL_WAKE_HALT, VIL_WAKE_HALT,
        VIL_WAKE_NONE, VIL_WAKE_NONE, VIL_WAKE_NONE,
        VIL_WAKE_NONE,
        VIL_WAKE_ACTIVE,
        VIL_WAKE_NONE,
        VIL_WAKE_ACTIVE,
        VIL_WAKE_HALT,
        VIL_WAKE_NONE
    };

    // ------------------------------------------------------------
    // pin synchronisers and line selection
    // ------------------------------------------------------------
    // all 16 pins of both ports are synchronised; first stage feeds second only
    logic [15:0] pinMeta_q, pinSync_q;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinMeta_q <= 16'hFFFF;
            pinSync_q <= 16'hFFFF;
        end
        else if (clkEn)
        begin
            pinMeta_q <= {portBPins, portAPins};
            pinSync_q <= pinMeta_q;
        end
    end

    logic [3:0] linePin;
    always_comb
    begin
        linePin[0] = pinSync_q[{2'b00, st_q.pinSel[`VIL_FLD_A +: 2]}];
        linePin[1] = pinSync_q[{2'b01, st_q.pinSel[`VIL_FLD_B +: 2]}];
        case (st_q.pinSel[`VIL_FLD_C +: 2])
            2'b00: linePin[2] = pinSync_q[11];
            2'b01: linePin[2] = pinSync_q[12];
            2'b10: linePin[2] = pinSync_q[13];
            default: linePin[2] = pinSync_q[14];
        endcase
        case (st_q.pinSel[`VIL_FLD_D +: 2])
            2'b01: linePin[3] = pinSync_q[9];
            2'b10: linePin[3] = pinSync_q[10];
            default: linePin[3] = pinSync_q[8];
        endcase
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic apbAccess, apbWrite, wrSense, wrPinSel, addrOk;
    logic [7:0] newSense;
    always_comb
    begin
        apbAccess = psel & penable;
        apbWrite = apbAccess & pwrite;
        addrOk = 1'b1;
        wrSense = 1'b0;
        wrPinSel = 1'b0;
        if (paddr == `VIL_OFF_SENSE)
            wrSense = apbWrite & cpuMask;
        else if (paddr == `VIL_OFF_PINSEL)
            wrPinSel = apbWrite;
        else if (paddr == `VIL_OFF_PEND || paddr == `VIL_OFF_VECT)
            addrOk = ~pwrite;
        else
            addrOk = 1'b0;
        newSense = wrSense ? pwdata[7:0] : st_q.sense;
    end
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~addrOk;

    // ------------------------------------------------------------
    // external line detectors
    // ------------------------------------------------------------
    logic [3:0] lineReq;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : gLine
            logic senseChg;
            logic ack;
            assign senseChg = newSense[2*gi +: 2] != st_q.sense[2*gi +: 2];
            assign ack = cpuAck && ackVector == 4'(`VIL_VN_LINE_A + gi);
            vil_line_detect uDet (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .clkEn(clkEn),
                .pinRaw(linePin[gi]),
                .sense(vil_sense_t'(st_q.sense[2*gi +: 2])),
                .senseChg(senseChg),
                .ackPulse(ack),
                .request(lineReq[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // pending, priority and wake
    // ------------------------------------------------------------
    logic [NUM_VEC-1:0] srcReq, canWake;
    logic found, anyWake;
    logic [3:0] winVec;
    logic [15:0] winAddr;
    always_comb
    begin
        st_d = st_q;
        st_d.sense = newSense;
        if (wrPinSel)
            st_d.pinSel = pwdata[7:0];
        // peripheral flags latch regardless of enable or mask; set wins over clear
        for (int i = 0; i < NUM_VEC; i++)
        begin
            if (periphFlag[i])
                st_d.pend[i] = 1'b1;
            else if (periphClear[i])
                st_d.pend[i] = 1'b0;
        end
        srcReq = st_q.pend & periphEnable;
        srcReq[`VIL_VN_LINE_A +: 4] = lineReq;
        canWake = '0;
        for (int i = 0; i < NUM_VEC; i++)
        begin
            case (WAKE_CLASS[i])
                VIL_WAKE_HALT: canWake[i] = haltMode != VIL_RUN;
                VIL_WAKE_ACTIVE: canWake[i] = haltMode == VIL_ACTIVE_HALT;
                VIL_WAKE_OSC: canWake[i] = haltMode == VIL_OSC_HALT;
                default: canWake[i] = 1'b0;
            endcase
        end
        // port B pin 4 on line c has no halt-time path
        if (st_q.pinSel[`VIL_FLD_C +: 2] == 2'b01)
            canWake[`VIL_VN_LINE_C] = 1'b0;
        anyWake = |(srcReq & canWake);
        // lowest number wins; trap above all maskable vectors
        found = 1'b0;
        winVec = 4'h0;
        for (int i = NUM_VEC - 1; i >= 0; i--)
        begin
            if (srcReq[i])
            begin
                found = 1'b1;
                winVec = 4'(i);
            end
        end
        winAddr = `VIL_VEC_BASE - {11'h000, winVec, 1'b0};
        if (trapReq)
        begin
            st_d.reqOut = 1'b1;
            st_d.addrOut = `VIL_VEC_TRAP;
            st_d.vecOut = 4'hF;
        end
        else
        begin
            st_d.reqOut = found & ~cpuMask;
            st_d.addrOut = winAddr;
            st_d.vecOut = winVec;
        end
        st_d.wakeOut = anyWake;
        // ack of a peripheral vector does not clear its flag; peripheral clears it
        st_d.rdata = 32'h0000_0000;
        if (paddr == `VIL_OFF_SENSE)
            st_d.rdata[7:0] = st_q.sense;
        else if (paddr == `VIL_OFF_PINSEL)
            st_d.rdata[7:0] = st_q.pinSel;
        else if (paddr == `VIL_OFF_PEND)
            st_d.rdata[NUM_VEC-1:0] = srcReq;
        else if (paddr == `VIL_OFF_VECT)
            st_d.rdata = {11'h000, st_q.reqOut, st_q.vecOut, st_q.addrOut};
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
            st_q.sense <= `VIL_SENSE_RST;
            st_q.pinSel <= `VIL_PINSEL_RST;
            st_q.addrOut <= `VIL_VEC_RESET;
        end
        else if (clkEn)
            st_q <= st_d;
    end

    // read data registered one cycle ahead from the setup-phase address
    assign prdata = st_q.rdata;
    assign irqReq = st_q.reqOut;
    assign irqVector = st_q.vecOut;
    assign irqAddr = st_q.addrOut;
    assign wakeUp = st_q.wakeOut;
endmodule
`default_nettype wire

// ==== rtl/vil_line_detect.sv ====
// one external line: synchroniser, sensitivity decode and request latch
// assumes the pin is asynchronous and ackPulse comes from core_clk logic
`include "vil_consts.svh"
`default_nettype none
module vil_line_detect
    import vil_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst_b, // async reset, low active
    input wire logic clkEn, // freezes state while low
    input wire logic pinRaw, // selected pin, asynchronous
    input wire vil_sense_t sense, // sensitivity field
    input wire logic senseChg, // sensitivity written with new value
    input wire logic ackPulse, // cpu entered this line's routine
    output logic request // pending request
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic latch;
    } vil_det_t;
    vil_det_t st_q, st_d;
    logic rise, fall, edgeHit, levelHit;

    always_comb
    begin
        st_d = st_q;
        rise = st_q.sync2 & ~st_q.prev;
        fall = ~st_q.sync2 & st_q.prev;
        edgeHit = 1'b0;
        levelHit = 1'b0;
        case (sense)
            VIL_SENSE_FALL_LOW:
            begin
                edgeHit = fall;
                levelHit = ~st_q.sync2;
            end
            VIL_SENSE_RISE: edgeHit = rise;
            VIL_SENSE_FALL: edgeHit = fall;
            default: edgeHit = rise | fall;
        endcase
        st_d.sync1 = pinRaw;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;
        // edges stay latched until serviced; set wins over ack
        if (edgeHit)
            st_d.latch = 1'b1;
        else if (ackPulse | senseChg)
            st_d.latch = 1'b0;
        // a new sensitivity drops whatever the old one caught
        if (senseChg)
            st_d.latch = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, latch: 1'b0};
        else if (clkEn)
            st_q <= st_d;
    end

    // low level requests directly, no latch; the falling edge is latched too, so the request holds after the pin returns high until ack
    assign request = st_q.latch | levelHit;
endmodule
`default_nettype wire

// ==== rtl/vil_pkg.sv ====
// types for the vectored interrupt / external line controller
// assumes vil_consts.svh alongside
`default_nettype none
package vil_pkg;
    typedef enum logic [1:0] {
        VIL_SENSE_FALL_LOW = 2'b00,
        VIL_SENSE_RISE = 2'b01,
        VIL_SENSE_FALL = 2'b10,
        VIL_SENSE_BOTH = 2'b11
    } vil_sense_t;
    typedef enum logic [1:0] {
        VIL_WAKE_NONE = 2'b00,
        VIL_WAKE_HALT = 2'b01,
        VIL_WAKE_ACTIVE = 2'b10,
        VIL_WAKE_OSC = 2'b11
    } vil_wake_t;
    typedef enum logic [1:0] {
        VIL_RUN = 2'b00,
        VIL_HALT = 2'b01,
        VIL_ACTIVE_HALT = 2'b10,
        VIL_OSC_HALT = 2'b11
    } vil_mode_t;
endpackage
`default_nettype wire
